// ===== shared/fanout_cfg_pkg.sv
// constants shared by the fan-out configuration logic
// assumes one 25 MHz system clock samples every programming pin
package fanout_cfg_pkg;
   localparam int CFG_BITS = 11;
   localparam int PAIRS = 10;
   localparam int SEL_BIT = 10;
   localparam int SYNC_STAGES = 3;
   localparam int COUNT_W = 4;
   // edges counted before the transfer edge; the twelfth edge moves the word
   localparam logic [COUNT_W-1:0] XFER_COUNT = 4'hB;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
   localparam logic [CFG_BITS-1:0] CFG_RESET = 11'h000;
   localparam logic [CFG_BITS-1:0] SHIFT_RESET = 11'h000;
   // pin levels assumed while a pin floats
   localparam logic PIN_ENABLE_RESET = 1'h0;
   localparam logic PIN_SERIAL_RESET = 1'h0;
   localparam logic PIN_SHIFT_CLK_RESET = 1'h1;
   localparam logic PIN_CLOCK_RESET = 1'h0;
   localparam logic [PAIRS-1:0] OE_N_RESET = 10'h000;
   localparam logic [PAIRS-1:0] OUT_P_RESET = 10'h000;
   localparam logic [PAIRS-1:0] OUT_N_RESET = 10'h3FF;
   typedef enum logic [1:0] {ST_OFF, ST_SHIFT, ST_HOLD} cfg_state_t;
endpackage

// ===== hw/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin inputs and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] next_level;

   // a change is accepted only once the second and third stages agree
   always_comb begin
      next_level = ((stage2 ^ stage3) & level) | (~(stage2 ^ stage3) & stage3);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         stage1 <= RESET_VALUE;
         stage2 <= RESET_VALUE;
         stage3 <= RESET_VALUE;
         level <= RESET_VALUE;
      end else begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
      end
   end

   assign level_o = level;
endmodule // pin_sync
`default_nettype wire

// ===== hw/serial_clock_fanout_config.sv
// serial programming port, control register and output gating of a 1:10 clock fan-out
// assumes all pins are asynchronous and sampled by the 25 MHz clock_i
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RQ1] programming only happens while program enable is high
// [RQ2] each shift-clock rising edge loads serial input and shifts all stages onward; the code shifts only on the eleven edges before the transfer edge
// [RQ3] a configuration is exactly eleven bits, bit 0 first, bit 10 last
// [RQ4] bit 0 drives pair nine down to bit 9 pair zero; bit 10 selects input
// [RQ5] a twelfth rising edge copies the shift register into the control register
// [RQ6] enable rising edge clears control register and arms twelve new edges
// [RQ7] enable low holds sequencer, shift and control registers in reset
// [RQ8] enable low, serial low: all pairs on, input a selected
// [RQ9] enable low, serial high: all pairs on, input b selected
// [RQ10] enable bit 1 drives pair, 0 floats it; select 0 is a, 1 is b
// [RQ11] true output follows positive differential input, inverted output complements it
// [RQ12] floating enable and serial read low, floating shift clock reads high
// [RQ13] after transfer further shift-clock edges leave control register unchanged
// [RQ14] with enable high outputs follow control register, all off until transfer
module serial_clock_fanout_config (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic program_enable_i,
   input wire logic serial_data_i,
   input wire logic program_shift_clock_i,
   input wire logic clock_input_a_p_i,
   input wire logic clock_input_a_n_i,
   input wire logic clock_input_b_p_i,
   input wire logic clock_input_b_n_i,
   output logic [fanout_cfg_pkg::PAIRS-1:0] out_p_o,
   output logic [fanout_cfg_pkg::PAIRS-1:0] out_n_o,
   output logic [fanout_cfg_pkg::PAIRS-1:0] out_oe_n_o,
   output logic [fanout_cfg_pkg::CFG_BITS-1:0] config_o,
   output logic config_done_o
);
   localparam int PAIRS = fanout_cfg_pkg::PAIRS;
   localparam int CFG_BITS = fanout_cfg_pkg::CFG_BITS;

   logic [6:0] pins_raw;
   logic [6:0] pins;
   logic prog_en;
   logic ser_in;
   logic shift_clk;
   logic a_level;
   logic b_level;

   // pull levels double as synchroniser reset values
   pin_sync #(
      .WIDTH(7),
      .RESET_VALUE({fanout_cfg_pkg::PIN_CLOCK_RESET, fanout_cfg_pkg::PIN_CLOCK_RESET,
                    fanout_cfg_pkg::PIN_CLOCK_RESET, fanout_cfg_pkg::PIN_CLOCK_RESET,
                    fanout_cfg_pkg::PIN_SHIFT_CLK_RESET, fanout_cfg_pkg::PIN_SERIAL_RESET,
                    fanout_cfg_pkg::PIN_ENABLE_RESET}) // RQ12
   ) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pin_i(pins_raw),
      .level_o(pins)
   );

   assign pins_raw = {clock_input_b_n_i, clock_input_b_p_i, clock_input_a_n_i,
                      clock_input_a_p_i, program_shift_clock_i, serial_data_i,
                      program_enable_i};
   assign prog_en = pins[0];
   assign ser_in = pins[1];
   assign shift_clk = pins[2];
   // an open or negative input reads low on the true output
   assign a_level = pins[3] & ~pins[4]; // RQ11
   assign b_level = pins[5] & ~pins[6]; // RQ11

   // ---- sequencer ----
   fanout_cfg_pkg::cfg_state_t state;
   fanout_cfg_pkg::cfg_state_t next_state;
   logic [fanout_cfg_pkg::COUNT_W-1:0] count;
   logic [fanout_cfg_pkg::COUNT_W-1:0] next_count;
   logic [CFG_BITS-1:0] shift;
   logic [CFG_BITS-1:0] next_shift;
   logic [CFG_BITS-1:0] cfg;
   logic [CFG_BITS-1:0] next_cfg;
   logic [CFG_BITS-1:0] cfg_from_shift;
   logic prev_en;
   logic prev_clk;
   logic en_rise;
   logic clk_rise;

   assign en_rise = prog_en & ~prev_en;
   assign clk_rise = shift_clk & ~prev_clk;

   // first bit in ends in the last stage, so the word is the stages reversed
   genvar k;
   generate
      for (k = 0; k < CFG_BITS; k++) begin : g_unpack
         assign cfg_from_shift[k] = shift[CFG_BITS-1-k]; // RQ3
      end
   endgenerate

   always_comb begin
      next_state = state;
      next_count = count;
      next_shift = shift;
      next_cfg = cfg;
      if (!prog_en) begin
         // nothing is taken while enable is low
         next_state = fanout_cfg_pkg::ST_OFF; // RQ1 RQ7
         next_count = fanout_cfg_pkg::COUNT_RESET;
         next_shift = fanout_cfg_pkg::SHIFT_RESET;
         next_cfg = fanout_cfg_pkg::CFG_RESET;
      end else if (en_rise) begin
         next_state = fanout_cfg_pkg::ST_SHIFT; // RQ6
         next_count = fanout_cfg_pkg::COUNT_RESET;
         next_shift = fanout_cfg_pkg::SHIFT_RESET;
         next_cfg = fanout_cfg_pkg::CFG_RESET;
      end else if (clk_rise) begin
         unique case (state)
            fanout_cfg_pkg::ST_SHIFT: begin
               if (count == fanout_cfg_pkg::XFER_COUNT) begin
                  next_cfg = cfg_from_shift; // RQ5
                  next_state = fanout_cfg_pkg::ST_HOLD;
               end else begin
                  next_shift = {shift[CFG_BITS-2:0], ser_in}; // RQ2
                  next_count = 4'(count + 4'h1); // RQ3
               end
            end
            // later edges are ignored until enable is cycled
            fanout_cfg_pkg::ST_HOLD: begin
               next_state = fanout_cfg_pkg::ST_HOLD; // RQ13
            end
            fanout_cfg_pkg::ST_OFF: begin
               next_state = fanout_cfg_pkg::ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state <= fanout_cfg_pkg::ST_OFF;
         count <= fanout_cfg_pkg::COUNT_RESET;
         shift <= fanout_cfg_pkg::SHIFT_RESET;
         cfg <= fanout_cfg_pkg::CFG_RESET;
         prev_en <= fanout_cfg_pkg::PIN_ENABLE_RESET;
         prev_clk <= fanout_cfg_pkg::PIN_SHIFT_CLK_RESET;
      end else begin
         state <= next_state;
         count <= next_count;
         shift <= next_shift;
         cfg <= next_cfg;
         prev_en <= prog_en;
         prev_clk <= shift_clk;
      end
   end

   // ---- output gating ----
   // the fanned clock is resampled at 25 MHz: a functional model, not a skew-true path
   logic sel;
   logic src;
   logic [PAIRS-1:0] pair_on;
   logic [PAIRS-1:0] out_p;
   logic [PAIRS-1:0] out_n;
   logic [PAIRS-1:0] oe_n;
   logic [PAIRS-1:0] next_out_p;
   logic [PAIRS-1:0] next_out_n;
   logic [PAIRS-1:0] next_oe_n;

   assign sel = prog_en ? cfg[fanout_cfg_pkg::SEL_BIT] : ser_in; // RQ4 RQ8 RQ9 RQ14
   assign src = sel ? b_level : a_level; // RQ10

   genvar j;
   generate
      for (j = 0; j < PAIRS; j++) begin : g_pair
         // pair j is steered by configuration bit 9-j
         assign pair_on[j] = prog_en ? cfg[PAIRS-1-j] : 1'h1; // RQ4 RQ8 RQ9 RQ14
      end
   endgenerate

   always_comb begin
      next_oe_n = ~pair_on; // RQ10
      next_out_p = pair_on & {PAIRS{src}}; // RQ11
      next_out_n = ~pair_on | {PAIRS{~src}}; // RQ11
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         out_p <= fanout_cfg_pkg::OUT_P_RESET;
         out_n <= fanout_cfg_pkg::OUT_N_RESET;
         oe_n <= fanout_cfg_pkg::OE_N_RESET;
      end else begin
         out_p <= next_out_p;
         out_n <= next_out_n;
         oe_n <= next_oe_n;
      end
   end

   assign out_p_o = out_p;
   assign out_n_o = out_n;
   assign out_oe_n_o = oe_n;
   assign config_o = cfg;
   assign config_done_o = (state == fanout_cfg_pkg::ST_HOLD);

   // ---- assertions ----
   property p_shift_edge;
      @(posedge clock_i) disable iff (rst_i)
      (prog_en && !en_rise && clk_rise && state == fanout_cfg_pkg::ST_SHIFT
       && count != fanout_cfg_pkg::XFER_COUNT)
      |=> (shift == {$past(shift[CFG_BITS-2:0]), $past(ser_in)});
   endproperty
   a_shift_edge: assert property (p_shift_edge) // RQ2
      else $error("shift register did not take the serial bit");

   property p_count_bound;
      @(posedge clock_i) disable iff (rst_i)
      count <= fanout_cfg_pkg::XFER_COUNT;
   endproperty
   a_count_bound: assert property (p_count_bound) // RQ3
      else $error("bit counter ran past eleven");

   property p_transfer;
      @(posedge clock_i) disable iff (rst_i)
      (prog_en && !en_rise && clk_rise && state == fanout_cfg_pkg::ST_SHIFT
       && count == fanout_cfg_pkg::XFER_COUNT)
      |=> (cfg == $past(cfg_from_shift)) && (state == fanout_cfg_pkg::ST_HOLD);
   endproperty
   a_transfer: assert property (p_transfer) // RQ5
      else $error("twelfth edge did not load the control register");

   property p_enable_rise;
      @(posedge clock_i) disable iff (rst_i)
      en_rise |=> (cfg == '0) && (count == '0) && (state == fanout_cfg_pkg::ST_SHIFT);
   endproperty
   a_enable_rise: assert property (p_enable_rise) // RQ6
      else $error("enable rise did not rearm the sequencer");

   property p_enable_low;
      @(posedge clock_i) disable iff (rst_i)
      !prog_en |=> (cfg == '0) && (shift == '0) && (state == fanout_cfg_pkg::ST_OFF);
   endproperty
   a_enable_low: assert property (p_enable_low) // RQ7
      else $error("state not held in reset while enable low");

   property p_default_a;
      @(posedge clock_i) disable iff (rst_i)
      (!prog_en && !ser_in) |=> (oe_n == '0) && (out_p == {PAIRS{$past(a_level)}});
   endproperty
   a_default_a: assert property (p_default_a) // RQ8
      else $error("default mode did not pass input a to all pairs");

   property p_default_b;
      @(posedge clock_i) disable iff (rst_i)
      (!prog_en && ser_in) |=> (oe_n == '0) && (out_p == {PAIRS{$past(b_level)}});
   endproperty
   a_default_b: assert property (p_default_b) // RQ9
      else $error("default mode did not pass input b to all pairs");

   property p_pair_off;
      @(posedge clock_i) disable iff (rst_i)
      (prog_en && !cfg[PAIRS-1]) |=> oe_n[0] && !out_p[0];
   endproperty
   a_pair_off: assert property (p_pair_off) // RQ10
      else $error("disabled pair zero still driven");

   property p_complement;
      @(posedge clock_i) disable iff (rst_i)
      (oe_n == '0) |-> (out_n == ~out_p);
   endproperty
   a_complement: assert property (p_complement) // RQ11
      else $error("inverted outputs not complementary");

   property p_hold;
      @(posedge clock_i) disable iff (rst_i)
      (state == fanout_cfg_pkg::ST_HOLD && prog_en && !en_rise) |=> $stable(cfg);
   endproperty
   a_hold: assert property (p_hold) // RQ13
      else $error("control register changed after transfer");

   property p_armed_off;
      @(posedge clock_i) disable iff (rst_i)
      (prog_en && state == fanout_cfg_pkg::ST_SHIFT) |=> (oe_n == {PAIRS{1'h1}});
   endproperty
   a_armed_off: assert property (p_armed_off) // RQ14
      else $error("outputs enabled before transfer");
endmodule // serial_clock_fanout_config
`default_nettype wire

// ===== tb/host_model.sv
// host controller model driving the enable, serial data and shift clock pins
// assumes the bench clock_i paces it and the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clock_i,
   output logic enable_o,
   output logic serial_o,
   output logic shift_clk_o
);
   // idle levels are those of the pin pulls, so a quiet host looks like open pins
   initial begin
      enable_o = 1'h0;
      serial_o = 1'h0;
      shift_clk_o = 1'h1;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // enable settles long enough before any shift edge
   task automatic set_enable(input logic v, input logic sd);
      enable_o = v;
      serial_o = sd;
      wait_cyc(8);
   endtask
   // 320 ns shift clock, stands high between frames; serial falls to its pull after hold
   task automatic send(input logic [10:0] word, input int edges);
      for (int i = 0; i < edges; i++) begin
         shift_clk_o = 1'h0;
         serial_o = (i < 11) ? word[i] : 1'h0;
         wait_cyc(4);
         shift_clk_o = 1'h1;
         wait_cyc(2);
         serial_o = 1'h0;
         wait_cyc(2);
      end
   endtask
endmodule // host_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the fan-out configuration logic
// assumes host_model drives the programming pins; expectations go through a queue
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock_i = 1'h0;
   logic rst_i = 1'h1;
   logic en, sd, sck, a_p, a_n, b_p, b_n, done;
   logic [9:0] out_p, out_n, oe_n;
   logic [10:0] cfg, word;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [41:0] exp_q[$];
   event look;
   always #20 clock_i = ~clock_i;
   host_model host (.clock_i(clock_i), .enable_o(en), .serial_o(sd), .shift_clk_o(sck));
   serial_clock_fanout_config uut (.clock_i(clock_i), .rst_i(rst_i),
      .program_enable_i(en), .serial_data_i(sd), .program_shift_clock_i(sck),
      .clock_input_a_p_i(a_p), .clock_input_a_n_i(a_n),
      .clock_input_b_p_i(b_p), .clock_input_b_n_i(b_n),
      .out_p_o(out_p), .out_n_o(out_n), .out_oe_n_o(oe_n),
      .config_o(cfg), .config_done_o(done));
   task automatic final_report();
      if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // open inputs (p equal to n) read low; pin to outputs takes about six cycles
   task automatic expect_now(input logic pe, input logic dn, input logic [10:0] w);
      logic [10:0] c;
      logic lvl;
      logic [9:0] oe, p;
      c = (pe && dn) ? w : 11'h000;
      lvl = (pe ? c[10] : sd) ? (b_p & ~b_n) : (a_p & ~a_n);
      for (int j = 0; j < 10; j++) begin
         oe[j] = pe ? ~c[9 - j] : 1'h0;
         p[j] = ~oe[j] & lvl;
      end
      exp_q.push_back({oe, p, ~p, dn, c});
      repeat (12) @(negedge clock_i);
      -> look;
   endtask
   always @(look) begin
      logic [41:0] e;
      e = exp_q.pop_front();
      check("out_oe_n_o", {1'h0, oe_n}, {1'h0, e[41:32]});
      check("out_p_o", {1'h0, out_p}, {1'h0, e[31:22]});
      check("out_n_o", {1'h0, out_n}, {1'h0, e[21:12]});
      check("config_done_o", {10'h000, done}, {10'h000, e[11]});
      check("config_o", cfg, e[10:0]);
   end
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      // the whole sequence needs about 1500 cycles
      if (cycles == 4000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h59A5D5BA));
      {a_p, a_n, b_p, b_n} = 4'h9;
      repeat (4) @(negedge clock_i);
      rst_i = 1'h0;
      expect_now(1'h0, 1'h0, 11'h000);
      host.set_enable(1'h0, 1'h1);
      expect_now(1'h0, 1'h0, 11'h000);
      {a_p, a_n, b_p, b_n} = 4'h6;
      expect_now(1'h0, 1'h0, 11'h000);
      {a_p, a_n, b_p, b_n} = 4'h7;
      expect_now(1'h0, 1'h0, 11'h000);
      for (int k = 0; k < 6; k++) begin
         word = (k == 0) ? 11'h7FF : 11'($urandom());
         word[10] = k[0];
         {a_p, a_n, b_p, b_n} = 4'($urandom());
         host.set_enable(1'h1, 1'h0);
         expect_now(1'h1, 1'h0, word);
         host.send(word, 12);
         expect_now(1'h1, 1'h1, word);
         host.send(~word, 3);
         expect_now(1'h1, 1'h1, word);
         host.set_enable(1'h0, 1'h0);
         expect_now(1'h0, 1'h0, word);
      end
      host.send(word, 12);
      expect_now(1'h0, 1'h0, word);
      host.set_enable(1'h1, 1'h0);
      host.send(~word, 6);
      host.set_enable(1'h0, 1'h0);
      host.set_enable(1'h1, 1'h0);
      host.send(word, 11);
      expect_now(1'h1, 1'h0, word);
      host.send(word, 1);
      expect_now(1'h1, 1'h1, word);
      // let the checker take the last note before the verdict
      @(negedge clock_i);
      final_report();
   end
endmodule // tb
`default_nettype wire
